// >>> dv/asr_core_tb.sv
// Purpose: self-checking bench for the async serial core
// Assumes: 50 MHz ref_clk; fastest rate is 16 clocks a bit
// Notes:   bus tasks leave one idle cycle between strobes
`timescale 1ns/1ps
module asr_core_tb
  import asr_pkg::*;
;
  logic       ref_clk, resetn, ce, halt, irq_mask, wr, rd, rxd, txd, irq;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  int         errors = 0;
  int         checks_done = 0;
  logic [7:0] brr_tab [6] = '{8'h00, 8'hc1, 8'h38, 8'h93, 8'h40, 8'h0a};
  logic [7:0] pre_tab [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h03};
  int         tclk_tab [6] = '{16, 208, 2048, 256, 240, 96};
  int         rclk_tab [6] = '{16, 416, 16, 512, 240, 192};

  asr_core u_asr_core (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .halt(halt),
    .irq_mask(irq_mask), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rxd(rxd), .txd(txd), .irq(irq));
  asr_remote u_asr_remote (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));

  always #10 ref_clk = ~ref_clk;

  // ------
  // bus and compare tasks
  // ------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic hang();
    errors++;
    $display("mismatch at %0t ns: wait ran out", $time);
    end_of_test();
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t ns: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk_reg(input logic [2:0] a, input logic [7:0] msk, input logic [7:0] e,
                         input string m);
    logic [7:0] d;
    rreg(a, d);
    chk({8'h00, d & msk}, {8'h00, e}, m);
  endtask

  task automatic chk_irq(input logic e);
    @(posedge ref_clk);
    #1 chk({15'h0000, irq}, {15'h0000, e}, "irq");
  endtask

  task automatic set_mask(input logic v);
    @(posedge ref_clk);
    irq_mask <= v;
  endtask

  // status polling only; a data write would clear tx done
  task automatic wait_tc();
    logic [7:0] s;
    int t;
    t = 0;
    do begin
      rreg(OFS_STAT, s);
      t++;
    end while (s[6] !== 1'b1 && t < 30000);
    if (t >= 30000) hang();
  endtask

  // ------
  // main sequence
  // ------
  initial begin
    logic [7:0] d;
    int n;
    ref_clk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    halt = 1'b0;
    irq_mask = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    chk_reg(OFS_STAT, 8'hff, RST_STAT, "status reset");
    chk_reg(OFS_CR2, 8'hff, RST_REG, "cr2 reset");
    wreg(OFS_CR2, 8'h04);
    u_asr_remote.send(9'h0a5, 8, 16, 1'b1, -1);
    chk_reg(OFS_STAT, 8'h2f, 8'h20, "rx full");
    chk_reg(OFS_DATA, 8'hff, 8'ha5, "rx data");
    u_asr_remote.send(9'h03c, 8, 16, 1'b1, 3);
    chk_reg(OFS_STAT, 8'h2f, 8'h24, "noise");
    chk_reg(OFS_DATA, 8'hff, 8'h3c, "majority");
    u_asr_remote.send(9'h05a, 8, 16, 1'b0, -1);
    chk_irq(1'b0);
    chk_reg(OFS_DATA, 8'hff, 8'h5a, "fe data");
    chk_reg(OFS_STAT, 8'h2f, 8'h22, "fe kept");
    chk_reg(OFS_DATA, 8'hff, 8'h5a, "fe data");
    chk_reg(OFS_STAT, 8'h2f, 8'h00, "fe clear");
    $display("test receive done");
    wreg(OFS_CR2, 8'h24);
    u_asr_remote.send(9'h011, 8, 16, 1'b1, -1);
    u_asr_remote.send(9'h022, 8, 16, 1'b1, -1);
    chk_irq(1'b1);
    set_mask(1'b1);
    chk_irq(1'b0);
    set_mask(1'b0);
    // broken stop above ends in a false start; its noise rides on the next frame
    chk_reg(OFS_STAT, 8'h2f, 8'h2c, "overrun");
    chk_reg(OFS_DATA, 8'hff, 8'h11, "old kept");
    chk_irq(1'b0);
    wreg(OFS_CR1, 8'h10);
    u_asr_remote.send(9'h1c3, 9, 16, 1'b1, -1);
    chk_reg(OFS_CR1, 8'h80, 8'h80, "ninth bit");
    chk_reg(OFS_STAT, 8'h2f, 8'h20, "rx9 full");
    chk_reg(OFS_DATA, 8'hff, 8'hc3, "rx9 data");
    wreg(OFS_CR2, 8'h04);
    for (int k = 0; k < 4; k++) begin
      wreg(OFS_CR1, {5'h00, 1'b1, k[1], 1'b1});
      u_asr_remote.send({1'b0, k[1] ^ k[0], 7'h35}, 8, 16, 1'b1, -1);
      chk_irq(k[0]);
      chk_reg(OFS_STAT, 8'h21, {7'h10, k[0]}, "parity");
      chk_reg(OFS_DATA, 8'hff, {k[1] ^ k[0], 7'h35}, "pair");
    end
    $display("test overrun and parity done");
    wreg(OFS_CR1, 8'h08);
    wreg(OFS_CR2, 8'h26);
    u_asr_remote.send(9'h055, 8, 16, 1'b0, -1);
    chk_irq(1'b0);
    chk_reg(OFS_STAT, 8'h2f, 8'h00, "muted");
    u_asr_remote.send(9'h0d5, 8, 16, 1'b1, -1);
    chk_irq(1'b1);
    chk_reg(OFS_CR2, 8'h02, 8'h00, "woken");
    // muted broken frame also ends in a false start, so noise is pending
    chk_reg(OFS_STAT, 8'h2f, 8'h24, "addr full");
    chk_reg(OFS_DATA, 8'hff, 8'hd5, "addr word");
    wreg(OFS_CR1, 8'h00);
    wreg(OFS_CR2, 8'h04);
    u_asr_remote.send(9'h0e7, 8, 16, 1'b1, -1);
    wreg(OFS_CR2, 8'h06);
    // a full idle frame is 160 clocks at this rate
    repeat (400) @(posedge ref_clk);
    chk_reg(OFS_CR2, 8'h02, 8'h00, "idle wake");
    chk_reg(OFS_STAT, 8'h10, 8'h00, "no idle");
    chk_reg(OFS_DATA, 8'hff, 8'he7, "idle data");
    $display("test mute done");
    for (int k = 0; k < 6; k++) begin
      wreg(OFS_CR2, 8'h00);
      wreg(OFS_BRR, brr_tab[k]);
      wreg(OFS_RXP, pre_tab[k]);
      wreg(OFS_TXP, pre_tab[k]);
      wreg(OFS_CR2, 8'h0c);
      rreg(OFS_STAT, d);
      wreg(OFS_DATA, 8'h01);
      u_asr_remote.meas_low(n);
      if (n < 0) hang();
      chk(n[15:0], tclk_tab[k][15:0], "tx bit time");
      u_asr_remote.send(9'h069, 8, rclk_tab[k], 1'b1, -1);
      chk_reg(OFS_STAT, 8'h20, 8'h20, "rx rate full");
      chk_reg(OFS_DATA, 8'hff, 8'h69, "rx rate data");
      wait_tc();
    end
    $display("test baud done");
    wreg(OFS_CR2, 8'h00);
    wreg(OFS_BRR, 8'h00);
    wreg(OFS_TXP, 8'h00);
    wreg(OFS_CR2, 8'h08);
    for (int k = 0; k < 2; k++) begin
      wreg(OFS_CR1, {5'h00, 1'b1, k[0], 1'b0});
      rreg(OFS_STAT, d);
      wreg(OFS_DATA, 8'hb5);
      u_asr_remote.cap(16, d, n);
      if (n < 0) hang();
      chk({8'h00, d}, {8'h00, k[0], 7'h35}, "tx parity");
      wait_tc();
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      ce <= k[0];
      halt <= k[0];
      wreg(OFS_CR2, 8'hf0);
      @(posedge ref_clk);
      ce <= 1'b1;
      halt <= 1'b0;
      chk_reg(OFS_CR2, 8'hff, 8'h08, "frozen");
    end
    for (int k = 6; k < 8; k++) begin
      wreg(OFS_CR2, 8'h01 << k);
      chk_irq(1'b1);
      set_mask(1'b1);
      chk_irq(1'b0);
      set_mask(1'b0);
    end
    $display("test transmit done");
    end_of_test();
  end
endmodule

// >>> dv/asr_remote.sv
// Purpose: remote serial device on the line side of the core
// Assumes: bit time given in ref_clk cycles
// Notes:   rxd rests high between frames; txd sampled mid-bit
`timescale 1ns/1ps
module asr_remote (
  input  wire logic ref_clk,
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;

  // ------
  // line driver
  // ------
  // gl flips one cycle where samples 8 to 10 sit
  task automatic put_bit(input logic v, input int bclk, input bit gl);
    for (int i = 0; i < bclk; i++) begin
      @(posedge ref_clk);
      rxd <= (gl && i == 9) ? ~v : v;
    end
  endtask

  // start, nb bits lsb first, stop; stp low breaks the frame
  task automatic send(input logic [8:0] w, input int nb, input int bclk,
                      input logic stp, input int gl);
    put_bit(1'b0, bclk, 1'b0);
    for (int b = 0; b < nb; b++) begin
      put_bit(w[b], bclk, gl == b);
    end
    put_bit(stp, bclk, 1'b0);
    put_bit(1'b1, 2, 1'b0);
  endtask

  // ------
  // line monitor
  // ------
  // n is -1 when no start bit turns up
  task automatic wait_fall(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (txd !== 1'b0 && n < 60000);
    if (n >= 60000) n = -1;
  endtask

  task automatic meas_low(output int n);
    wait_fall(n);
    if (n >= 0) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (txd === 1'b0 && n < 60000);
    end
  endtask

  task automatic cap(input int bclk, output logic [7:0] d, output int n);
    d = 8'h00;
    wait_fall(n);
    if (n >= 0) begin
      repeat (bclk / 2) @(posedge ref_clk);
      for (int b = 0; b < 8; b++) begin
        repeat (bclk) @(posedge ref_clk);
        d[b] = txd;
      end
    end
  endtask
endmodule

// >>> pkg/asr_pkg.sv
// Purpose: constants for the async serial core
// Assumes: 8-bit register port, 50 MHz ref_clk
// Notes:   offsets are word indices on the plain port
package asr_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [2:0] OFS_STAT = 3'h0;
  localparam logic [2:0] OFS_DATA = 3'h1;
  localparam logic [2:0] OFS_BRR  = 3'h2;
  localparam logic [2:0] OFS_CR1  = 3'h3;
  localparam logic [2:0] OFS_CR2  = 3'h4;
  localparam logic [2:0] OFS_RXP  = 3'h5;
  localparam logic [2:0] OFS_TXP  = 3'h6;
  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] RST_STAT = 8'hc0;
  localparam logic [7:0] RST_REG  = 8'h00;
  localparam int CR1_R8   = 7;
  localparam int CR1_T8   = 6;
  localparam int CR1_M    = 4;
  localparam int CR1_WAKE = 3;
  localparam int CR1_PCE  = 2;
  localparam int CR1_PS   = 1;
  localparam int CR1_PIE  = 0;
  localparam int CR2_TIE  = 7;
  localparam int CR2_TX_DONE_IRQ_ENABLE = 6;
  localparam int CR2_RIE  = 5;
  localparam int CR2_LINE_QUIET_IRQ_ENABLE = 4;
  localparam int CR2_TE   = 3;
  localparam int CR2_RE   = 2;
  localparam int CR2_MUTE = 1;
  localparam int BRR_BASE = 6;
  localparam int BRR_TX   = 3;
  localparam int BRR_RX   = 0;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] SMP_8    = 4'h7;
  localparam logic [3:0] SMP_9    = 4'h8;
  localparam logic [3:0] SMP_10   = 4'h9;
  localparam logic [3:0] SMP_3    = 4'h2;
  localparam logic [3:0] SMP_5    = 4'h4;
  localparam logic [3:0] SMP_7    = 4'h6;
  localparam logic [4:0] BASE_DIV0 = 5'h01;
  localparam logic [4:0] BASE_DIV1 = 5'h03;
  localparam logic [4:0] BASE_DIV2 = 5'h04;
  localparam logic [4:0] BASE_DIV3 = 5'h0d;
  localparam logic [3:0] FLEN_8 = 4'ha;
  localparam logic [3:0] FLEN_9 = 4'hb;
endpackage

// >>> rtl/asr_core.sv
// Purpose: async serial core with baud dividers, parity, mute
// Assumes: inputs synchronous to ref_clk; plain register port
// Notes:   one packed state struct, two comb and one ff process
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module asr_core
  import asr_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       halt,
  input  wire logic       irq_mask,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       rxd,
  output logic            txd,
  output logic            irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } asr_rx_t;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'h1,
    TX_SHIFT = 2'h2
  } asr_tx_t;
  typedef struct packed {
    logic [7:0]  cr1;
    logic [7:0]  cr2;
    logic [7:0]  brr;
    logic [7:0]  rxp;
    logic [7:0]  txp;
    logic        tx_empty_flag;
    logic        tc;
    logic        rx_full_flag;
    logic        idle;
    logic        ovr;
    logic        nf;
    logic        fe;
    logic        pe;
    logic        seen;
    logic [7:0]  rdr;
    logic [7:0]  rdata;
    logic [18:0] rx_div;
    asr_rx_t     rx_st;
    logic [3:0]  rx_cnt;
    logic [3:0]  rx_bit;
    logic [2:0]  rx_hist;
    logic [2:0]  rx_smp;
    logic [8:0]  rx_w;
    logic        rx_nf;
    logic [7:0]  quiet;
    logic        armed;
    logic [18:0] tx_div;
    asr_tx_t     tx_st;
    logic [3:0]  tx_cnt;
    logic [3:0]  tx_bit;
    logic [10:0] tx_sh;
    logic [8:0]  tdr;
    logic        tx_data;
    logic        te_q;
  } asr_state_t;

  asr_state_t st;
  asr_state_t next_st;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [18:0] div_lim(
    input logic [1:0] base_sel,
    input logic [2:0] rate_sel,
    input logic [7:0] fine
  );
    logic [4:0]  base;
    logic [18:0] prod;
    case (base_sel)
      2'h0:    base = BASE_DIV0;
      2'h1:    base = BASE_DIV1;
      2'h2:    base = BASE_DIV2;
      default: base = BASE_DIV3;
    endcase
    prod = 19'(base) << rate_sel;
    if (fine != 8'h00) begin
      prod = 19'(prod * 19'(fine));
    end
    div_lim = prod - 19'h1;
  endfunction

  logic        en;
  logic        m_len;
  logic [3:0]  flen;
  logic        rx_tick;
  logic        tx_tick;
  logic [18:0] rx_lim;
  logic [18:0] tx_lim;
  logic [8:0]  tx_frame;
  logic [8:0]  word;
  logic        maj;
  logic        msb;
  logic        perr;
  logic        frame_end;
  logic        stop_ok;
  logic [2:0]  smp3;

  assign en    = ce & !halt;
  assign m_len = st.cr1[CR1_M];
  assign flen  = m_len ? FLEN_9 : FLEN_8;
  assign rx_lim = div_lim(st.brr[BRR_BASE+:2], st.brr[BRR_RX+:3], st.rxp);
  assign tx_lim = div_lim(st.brr[BRR_BASE+:2], st.brr[BRR_TX+:3], st.txp);
  assign rx_tick = (st.rx_div == rx_lim);
  assign tx_tick = (st.tx_div == tx_lim);
  assign smp3 = {st.rx_smp[1:0], rxd};
  assign maj  = (smp3[0] & smp3[1]) | (smp3[0] & smp3[2]) |
                (smp3[1] & smp3[2]);
  assign word = m_len ? st.rx_w : {1'b0, st.rx_w[8:1]};
  assign msb  = m_len ? word[8] : word[7];
  // received parity covers data plus parity bit
  assign perr = (m_len ? ^word[8:0] : ^word[7:0]) ^
                st.cr1[CR1_PS];
  assign frame_end = en & rx_tick & (st.rx_st == RX_STOP) &
                     (st.rx_cnt == SMP_10);
  assign stop_ok = maj;

  // parity replaces the msb of the written word
  always_comb begin
    tx_frame = m_len ? {st.cr1[CR1_T8], wdata} : {1'b0, wdata};
    if (st.cr1[CR1_PCE]) begin
      if (m_len) begin
        tx_frame[8] = ^wdata[7:0] ^ st.cr1[CR1_PS];
      end else begin
        tx_frame[7] = ^wdata[6:0] ^ st.cr1[CR1_PS];
      end
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (en) begin
      // bus side first so that hardware sets win
      if (rd) begin
        case (addr)
          OFS_STAT: next_st.rdata = {st.tx_empty_flag, st.tc, st.rx_full_flag, st.idle,
                                     st.ovr, st.nf, st.fe, st.pe};
          OFS_DATA: next_st.rdata = st.rdr;
          OFS_BRR:  next_st.rdata = st.brr;
          OFS_CR1:  next_st.rdata = st.cr1;
          OFS_CR2:  next_st.rdata = st.cr2;
          OFS_RXP:  next_st.rdata = st.rxp;
          OFS_TXP:  next_st.rdata = st.txp;
          default:  next_st.rdata = RST_REG;
        endcase
        if (addr == OFS_STAT) begin
          next_st.seen = 1'b1;
        end
        if (addr == OFS_DATA) begin
          next_st.seen = 1'b0;
          if (st.seen) begin
            next_st.rx_full_flag = 1'b0;
            next_st.idle = 1'b0;
            next_st.ovr  = 1'b0;
            next_st.nf   = 1'b0;
            next_st.fe   = 1'b0;
            next_st.pe   = 1'b0;
          end
        end
      end
      if (wr) begin
        case (addr)
          OFS_BRR: next_st.brr = wdata;
          OFS_CR1: next_st.cr1 = {st.cr1[CR1_R8], wdata[6:0]};
          OFS_CR2: next_st.cr2 = wdata;
          OFS_RXP: next_st.rxp = wdata;
          OFS_TXP: next_st.txp = wdata;
          default: next_st.cr2 = next_st.cr2;
        endcase
        if (addr == OFS_DATA) begin
          next_st.seen = 1'b0;
          if (st.seen) begin
            next_st.tc = 1'b0;
          end
          if (st.tx_st == TX_IDLE && st.cr2[CR2_TE]) begin
            next_st.tx_st   = TX_SHIFT;
            // stop bit must sit right above the last data bit
            next_st.tx_sh   = m_len ? {1'b1, tx_frame, 1'b0} :
                              {2'b11, tx_frame[7:0], 1'b0};
            next_st.tx_cnt  = 4'h0;
            next_st.tx_bit  = 4'h0;
            next_st.tx_data = 1'b1;
            next_st.tx_div  = 19'h0;
            next_st.tx_empty_flag    = 1'b1;
          end else begin
            next_st.tdr  = tx_frame;
            next_st.tx_empty_flag = 1'b0;
          end
        end
      end

      // ----------------------------------------
      // transmitter
      // ----------------------------------------
      next_st.te_q = st.cr2[CR2_TE];
      if (!st.cr2[CR2_TE]) begin
        next_st.tx_st = TX_IDLE;
      end else if (!st.te_q) begin
        // enable starts with one all-ones frame
        next_st.tx_st   = TX_SHIFT;
        next_st.tx_sh   = '1;
        next_st.tx_cnt  = 4'h0;
        next_st.tx_bit  = 4'h0;
        next_st.tx_data = 1'b0;
        next_st.tx_div  = 19'h0;
      end else if (st.tx_st == TX_SHIFT && !(wr && addr == OFS_DATA)) begin
        next_st.tx_div = tx_tick ? 19'h0 : st.tx_div + 19'h1;
        if (tx_tick) begin
          next_st.tx_cnt = st.tx_cnt + 4'h1;
          if (st.tx_cnt == OVS_LAST) begin
            next_st.tx_sh  = {1'b1, st.tx_sh[10:1]};
            next_st.tx_bit = st.tx_bit + 4'h1;
            if (st.tx_bit == flen - 4'h1) begin
              next_st.tx_bit = 4'h0;
              if (!st.tx_empty_flag) begin
                next_st.tx_sh   = m_len ? {1'b1, st.tdr, 1'b0} :
                                  {2'b11, st.tdr[7:0], 1'b0};
                next_st.tx_empty_flag    = 1'b1;
                next_st.tx_data = 1'b1;
              end else begin
                next_st.tx_st = TX_IDLE;
                next_st.tc    = st.tx_data | st.tc;
              end
            end
          end
        end
      end

      // ----------------------------------------
      // receiver
      // ----------------------------------------
      if (!st.cr2[CR2_RE]) begin
        next_st.rx_st  = RX_IDLE;
        next_st.rx_div = 19'h0;
      end else begin
        next_st.rx_div = rx_tick ? 19'h0 : st.rx_div + 19'h1;
      end
      if (st.cr2[CR2_RE] && rx_tick) begin
        next_st.rx_cnt = st.rx_cnt + 4'h1;
        if (st.rx_cnt == SMP_8 || st.rx_cnt == SMP_9) begin
          next_st.rx_smp = smp3;
        end
        case (st.rx_st)
          RX_IDLE: begin
            next_st.rx_hist = {st.rx_hist[1:0], rxd};
            if (!rxd) begin
              next_st.rx_st  = RX_START;
              next_st.rx_cnt = 4'h0;
              next_st.quiet  = 8'h0;
              if (st.rx_hist != 3'h7) begin
                next_st.rx_nf = 1'b1;
              end
            end else if (st.quiet == {flen, 4'h0} - 8'h1) begin
              next_st.quiet = 8'h0;
              if (st.armed) begin
                next_st.armed = 1'b0;
                if (st.cr2[CR2_MUTE]) begin
                  if (!st.cr1[CR1_WAKE]) begin
                    next_st.cr2[CR2_MUTE] = 1'b0;
                  end
                end else begin
                  next_st.idle = 1'b1;
                end
              end
            end else begin
              next_st.quiet = st.quiet + 8'h1;
            end
          end
          RX_START: begin
            if ((st.rx_cnt == SMP_3 || st.rx_cnt == SMP_5 ||
                 st.rx_cnt == SMP_7) && rxd) begin
              next_st.rx_nf = 1'b1;
            end
            if (st.rx_cnt == SMP_10) begin
              if (|smp3) begin
                next_st.rx_nf = 1'b1;
              end
              if (maj) begin
                // false start: frame dropped, noise kept
                next_st.rx_st   = RX_IDLE;
                next_st.rx_hist = 3'h7;
              end
            end
            if (st.rx_cnt == OVS_LAST) begin
              next_st.rx_st  = RX_DATA;
              next_st.rx_bit = 4'h0;
            end
          end
          RX_DATA: begin
            if (st.rx_cnt == SMP_10) begin
              next_st.rx_w = {maj, st.rx_w[8:1]};
              if (smp3 != 3'h0 && smp3 != 3'h7) begin
                next_st.rx_nf = 1'b1;
              end
            end
            if (st.rx_cnt == OVS_LAST) begin
              next_st.rx_bit = st.rx_bit + 4'h1;
              if (st.rx_bit == flen - 4'h3) begin
                next_st.rx_st = RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (st.rx_cnt == SMP_10) begin
              next_st.rx_st   = RX_IDLE;
              next_st.rx_hist = stop_ok ? 3'h7 : 3'h0;
              next_st.rx_nf   = 1'b0;
              next_st.armed   = 1'b1;
            end
          end
          default: next_st.rx_st = RX_IDLE;
        endcase
      end

      // frame delivery
      if (frame_end) begin
        if (st.cr2[CR2_MUTE] && st.cr1[CR1_WAKE] && msb) begin
          next_st.cr2[CR2_MUTE] = 1'b0;
        end
        if (!st.cr2[CR2_MUTE] || (st.cr1[CR1_WAKE] && msb)) begin
          if (st.rx_full_flag && !(rd && addr == OFS_DATA && st.seen)) begin
            next_st.ovr = 1'b1;
          end else begin
            next_st.rdr          = word[7:0];
            next_st.cr1[CR1_R8]  = word[8];
            next_st.rx_full_flag         = 1'b1;
            next_st.fe           = !stop_ok;
            next_st.nf           = st.rx_nf | (smp3 != 3'h0 && smp3 != 3'h7);
            next_st.pe           = st.cr1[CR1_PCE] & perr;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st       <= '0;
      st.tx_empty_flag  <= RST_STAT[7];
      st.tc    <= RST_STAT[6];
      st.rx_st <= RX_IDLE;
      st.tx_st <= TX_IDLE;
      st.rx_hist <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata = st.rdata;
  assign txd   = (st.tx_st == TX_SHIFT) ? st.tx_sh[0] : 1'b1;
  assign irq = !irq_mask & (
      (st.tx_empty_flag & st.cr2[CR2_TIE]) |
      (st.tc & st.cr2[CR2_TX_DONE_IRQ_ENABLE]) |
      (!st.cr2[CR2_MUTE] & (
        ((st.rx_full_flag | st.ovr) & st.cr2[CR2_RIE]) |
        (st.idle & st.cr2[CR2_LINE_QUIET_IRQ_ENABLE]) |
        (st.pe & st.cr1[CR1_PIE]))));

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_data_read;
    $past(rd) && $past(addr) == OFS_DATA && $past(st.seen);
  endsequence

  a_fe_with_rx_full_flag: assert property ($rose(st.fe) |-> $rose(st.rx_full_flag))
    else $error("framing error without rx full");
  a_fe_clear_seq: assert property ($fell(st.fe) |-> s_data_read)
    else $error("framing error cleared without read pair");
  a_mute_no_flag: assert property (
      $past(st.cr2[CR2_MUTE]) && st.cr2[CR2_MUTE] |->
      !$rose(st.rx_full_flag) && !$rose(st.idle))
    else $error("status set while muted");
  a_idle_wake_q: assert property (
      $fell(st.cr2[CR2_MUTE]) && !$past(st.cr1[CR1_WAKE]) && $past(en)
      && !$past(wr) |-> !$rose(st.idle))
    else $error("idle flag on idle wake");
  a_addr_wake: assert property (
      $fell(st.cr2[CR2_MUTE]) && $past(st.cr1[CR1_WAKE]) && !$past(wr)
      |-> st.rx_full_flag)
    else $error("address wake without rx full");
  a_pe_enabled: assert property ($rose(st.pe) |-> st.cr1[CR1_PCE])
    else $error("parity error with parity off");
  a_nf_rx_full_flag: assert property ($rose(st.nf) |-> $rose(st.rx_full_flag))
    else $error("noise flag not with rx full");
  a_halt_frozen: assert property (
      $past(halt) && !$past(wr) && !$past(rd) |-> $stable(st))
    else $error("state moved in halt");
  a_irq_masked: assert property (irq_mask |-> !irq)
    else $error("irq while masked");
  a_rx_irq: assert property (
      !irq_mask && st.cr2[CR2_RIE] && !st.cr2[CR2_MUTE] && st.ovr
      |-> irq)
    else $error("overrun without irq");
  a_div_bound: assert property (st.rx_div <= rx_lim || $changed(st.brr)
      || $changed(st.rxp))
    else $error("rx divider beyond limit");
endmodule
